// ---- common/pot_params.svh ----
// constants and functional notes for the quad potentiometer link
// Functional notes
// - first byte: type code, then strap address
// - second byte: opcode, setting select, pot select
// - opcode 1001 returns selected wiper register
// - opcode 1010 loads data into wiper
// - opcode 1011 returns selected stored setting
// - opcode 1100 writes data into stored setting
// - opcode 1101 copies setting into wiper
// - opcode 1110 copies wiper into setting
// - opcode 0001, pot 00: all settings to wipers
// - opcode 1000, pot 00: all wipers to settings
// - opcode 0010 arms wiper stepping
// - register read/write takes three bytes
// - transfers take two bytes, no data
// - wiper tap follows a transfer after response delay
// - wiper to setting starts timed write
// - scl pulse, sda high: step up
// - scl pulse, sda low: step down
// - ack valid id, instruction, write data
// - during nonvolatile write ignore the bus
// - setting writes finish within 10 ms
`ifndef POT_PARAMS_SVH
`define POT_PARAMS_SVH

`define CLK_MHZ      20
`define NV_WRITE_MS  10
`define WRL_NS       1000
`define SCL_TICK     4'h4
`define ACK_BIT      4'h8
`define WIPER_MAX    8'hff
`define WIPER_MIN    8'h00

`define REG_CMD      8'h00
`define REG_ADDR     8'h04
`define REG_STAT     8'h08
`define CMD_INSTR    7:0
`define CMD_DATA     15:8
`define CMD_STEPS    23:16
`define CMD_UP       24
`define ADDR_STRAP   3:0

`endif

// ---- common/pot_pkg.sv ----
// types and instruction decode shared by both link ends
package pot_pkg;

  typedef enum logic [3:0] {
    OP_GXFR_TO_WIPER = 4'h1,
    OP_INCDEC        = 4'h2,
    OP_GXFR_TO_STORE = 4'h8,
    OP_RD_WIPER      = 4'h9,
    OP_WR_WIPER      = 4'ha,
    OP_RD_STORE      = 4'hb,
    OP_WR_STORE      = 4'hc,
    OP_XFR_TO_WIPER  = 4'hd,
    OP_XFR_TO_STORE  = 4'he
  } opcode_t;

  typedef struct packed {
    logic [3:0] opcode;
    logic       setting_select_hi;
    logic       setting_select_lo;
    logic       pot_select_hi;
    logic       pot_select_lo;
  } instr_t;

  typedef enum logic [7:0] {
    D_IDLE  = 8'h01,
    D_ID    = 8'h02,
    D_INSTR = 8'h04,
    D_RX    = 8'h08,
    D_TX    = 8'h10,
    D_STEP  = 8'h20,
    D_DONE  = 8'h40,
    D_BUSY  = 8'h80
  } dev_state_t;

  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_START = 5'h02,
    H_BIT   = 5'h04,
    H_STEP  = 5'h08,
    H_STOP  = 5'h10
  } host_state_t;

  function automatic logic instr_ok(instr_t i);
    logic sel0;
    logic pot0;
    logic ok;
    sel0 = ({i.setting_select_hi, i.setting_select_lo} == 2'h0);
    pot0 = ({i.pot_select_hi, i.pot_select_lo} == 2'h0);
    case (i.opcode)
      OP_RD_WIPER, OP_WR_WIPER, OP_INCDEC:         ok = sel0;
      OP_RD_STORE, OP_WR_STORE,
      OP_XFR_TO_WIPER, OP_XFR_TO_STORE:            ok = 1'b1;
      OP_GXFR_TO_WIPER, OP_GXFR_TO_STORE:          ok = pot0;
      default:                                     ok = 1'b0;
    endcase
    return ok;
  endfunction : instr_ok

  function automatic logic has_data(logic [3:0] op);
    return (op == OP_RD_WIPER) || (op == OP_WR_WIPER) ||
           (op == OP_RD_STORE) || (op == OP_WR_STORE);
  endfunction : has_data

  function automatic logic is_read(logic [3:0] op);
    return (op == OP_RD_WIPER) || (op == OP_RD_STORE);
  endfunction : is_read

endpackage : pot_pkg

// ---- common/pot_link_if.sv ----
// two-wire link between host controller and pot device
`timescale 1ns/1ns
interface pot_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  wire  sda;

  // open drain with pull-up: a driver only ever pulls low
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host   (output scl, output host_sda_o, output host_sda_oe_n,
                  input sda);
  modport device (input scl, input sda, output dev_sda_o,
                  output dev_sda_oe_n);
endinterface : pot_link_if

// ---- rtl/link_sampler.sv ----
// two-flop synchroniser with a third stage for edge finding
`timescale 1ns/1ns
module link_sampler #(
  parameter int W = 2
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_q,
  output logic      [W-1:0] o_prev
);
  logic [W-1:0] meta;

  // reset to the idle level of a pulled-up pin, so that no false edge
  // follows reset; a strap input simply settles two cycles later
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta   <= '1;
      o_q    <= '1;
      o_prev <= '1;
    end else begin
      meta   <= i_pin;
      o_q    <= meta;
      o_prev <= o_q;
    end
  end
endmodule : link_sampler

// ---- rtl/pot_device.sv ----
// pot device end: command decoder, wiper and stored-setting registers
`timescale 1ns/1ns
`include "pot_params.svh"
module pot_device
  import pot_pkg::*;
#(
  // arbitrary value
  parameter logic [3:0] TYPE_CODE       = 4'ha,
  parameter int         NV_WRITE_CYCLES = `NV_WRITE_MS * 1000 * `CLK_MHZ
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [3:0] i_addr_strap,
  pot_link_if.device      link,
  output logic      [7:0] o_tap [4],
  output logic            o_nv_busy
);
  localparam int WRL_CYCLES = (`WRL_NS * `CLK_MHZ + 999) / 1000;

  logic [1:0]  pin_q;
  logic [1:0]  pin_p;
  logic [3:0]  strap;
  dev_state_t  state;
  dev_state_t  next_state;
  logic [3:0]  bitcnt;
  logic [7:0]  shreg;
  logic [7:0]  txbyte;
  instr_t      instr;
  logic        nv_pend;
  logic        step_arm;
  logic [31:0] nv_cnt;
  logic [7:0]  wcr [4];
  logic [7:0]  bank_rd [4];

  link_sampler #(.W(2)) u_link (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   ({link.scl, link.sda}),
    .o_q     (pin_q),
    .o_prev  (pin_p)
  );

  link_sampler #(.W(4)) u_strap (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_addr_strap),
    .o_q     (strap),
    .o_prev  ()
  );

  wire sda        = pin_q[0];
  wire scl_rise   = pin_q[1] & ~pin_p[1];
  wire scl_fall   = ~pin_q[1] & pin_p[1];
  wire start_cond = pin_q[1] & pin_p[1] & pin_p[0] & ~sda;
  wire stop_cond  = pin_q[1] & pin_p[1] & ~pin_p[0] & sda;
  wire byte_done  = scl_fall & (bitcnt == `ACK_BIT);

  wire id_ok   = (shreg == {TYPE_CODE, strap});
  wire ins_ok  = instr_ok(instr_t'(shreg));
  wire ev_id   = byte_done & (state == D_ID);
  wire ev_ins  = byte_done & (state == D_INSTR) & ins_ok;
  wire ev_rx   = byte_done & (state == D_RX);
  wire ack_now = (ev_id & id_ok) | ev_ins | ev_rx;

  wire instr_t     cur     = ev_ins ? instr_t'(shreg) : instr;
  wire [3:0]       cur_op  = cur.opcode;
  wire [1:0]       cur_sel = {cur.setting_select_hi, cur.setting_select_lo};
  wire [1:0]       cur_pot = {cur.pot_select_hi, cur.pot_select_lo};

  // transfers act on the instruction byte
  wire do_xfr_w  = ev_ins & (cur_op == OP_XFR_TO_WIPER);
  wire do_gxfr_w = ev_ins & (cur_op == OP_GXFR_TO_WIPER);
  wire do_xfr_s  = ev_ins & (cur_op == OP_XFR_TO_STORE);
  wire do_gxfr_s = ev_ins & (cur_op == OP_GXFR_TO_STORE);
  // writes act on the data byte
  wire do_wr_w   = ev_rx & (cur_op == OP_WR_WIPER);
  wire do_wr_s   = ev_rx & (cur_op == OP_WR_STORE);
  // a step counts at the end of its high pulse: the stop's own rise
  // never falls inside stepping, so it cannot move the wiper
  wire step      = (state == D_STEP) & scl_fall & step_arm;
  wire nv_start  = do_wr_s | do_xfr_s | do_gxfr_s;

  always_comb begin
    next_state = state;
    unique case (state)
      D_ID:    next_state = id_ok ? D_INSTR : D_IDLE;
      D_INSTR: begin
        if (!ins_ok)
          next_state = D_IDLE;
        else if (shreg[7:4] == OP_INCDEC)
          next_state = D_STEP;
        else if (is_read(shreg[7:4]))
          next_state = D_TX;
        else if (has_data(shreg[7:4]))
          next_state = D_RX;
        else
          next_state = D_DONE;
      end
      D_RX, D_TX: next_state = D_DONE;
      D_IDLE, D_STEP, D_DONE, D_BUSY: next_state = state;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      instr  <= '0;
      txbyte <= `WIPER_MIN;
    end else if (ev_ins) begin
      instr  <= instr_t'(shreg);
      txbyte <= (cur_op == OP_RD_WIPER) ? wcr[cur_pot] : bank_rd[cur_pot];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state             <= D_IDLE;
      bitcnt            <= 4'h0;
      shreg             <= `WIPER_MIN;
      nv_pend           <= 1'b0;
      step_arm          <= 1'b0;
      nv_cnt            <= '0;
      link.dev_sda_oe_n <= 1'b1;
      link.dev_sda_o    <= 1'b0;
      o_nv_busy         <= 1'b0;
    end else begin
      o_nv_busy <= (state == D_BUSY);
      if (state == D_BUSY) begin
        // deaf to the bus while writing
        link.dev_sda_oe_n <= 1'b1;
        if (nv_cnt == 32'h0000_0000)
          state <= D_IDLE;
        else
          nv_cnt <= nv_cnt - 32'h0000_0001;
      end else if (stop_cond) begin
        link.dev_sda_oe_n <= 1'b1;
        nv_pend           <= 1'b0;
        step_arm          <= 1'b0;
        if (nv_pend) begin
          state  <= D_BUSY;
          nv_cnt <= 32'(NV_WRITE_CYCLES - 1);
        end else begin
          state <= D_IDLE;
        end
      end else if (start_cond) begin
        state             <= D_ID;
        bitcnt            <= 4'h0;
        step_arm          <= 1'b0;
        link.dev_sda_oe_n <= 1'b1;
      end else begin
        if (nv_start)
          nv_pend <= 1'b1;
        if (scl_rise) begin
          // the ack clock's own rise is not a step
          step_arm <= (state == D_STEP) & (bitcnt != `ACK_BIT);
          if (bitcnt == `ACK_BIT) begin
            bitcnt <= 4'h0;
          end else if (state != D_STEP) begin
            bitcnt <= bitcnt + 4'h1;
            shreg  <= {shreg[6:0], sda};
          end
        end
        if (scl_fall) begin
          step_arm <= 1'b0;
          if (bitcnt == `ACK_BIT) begin
            // no ack on a refused id or instruction leaves the device idle
            link.dev_sda_oe_n <= ~ack_now;
            state             <= next_state;
          end else if (state == D_TX) begin
            link.dev_sda_oe_n <= txbyte[~bitcnt[2:0]];
          end else begin
            link.dev_sda_oe_n <= 1'b1;
          end
        end
      end
    end
  end

  for (genvar c = 0; c < 4; c++) begin : g_ch
    logic [7:0] bank [4];
    logic [7:0] dly;
    wire        hit    = (cur_pot == 2'(c));
    wire        ld_wip = (do_xfr_w & hit) | do_gxfr_w;
    wire        st_we  = ((do_wr_s | do_xfr_s) & hit) | do_gxfr_s;
    wire [7:0]  st_val = do_wr_s ? shreg : wcr[c];

    assign bank_rd[c] = bank[cur_sel];

    always_ff @(posedge i_clk) begin
      if (!i_rst_n)
        wcr[c] <= `WIPER_MIN;
      else if (do_wr_w & hit)
        wcr[c] <= shreg;
      else if (ld_wip)
        wcr[c] <= bank[cur_sel];
      else if (step & hit & sda & (wcr[c] != `WIPER_MAX))
        wcr[c] <= wcr[c] + 8'h01;
      else if (step & hit & ~sda & (wcr[c] != `WIPER_MIN))
        wcr[c] <= wcr[c] - 8'h01;
    end

    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        for (int k = 0; k < 4; k++)
          bank[k] <= `WIPER_MIN;
      end else if (st_we) begin
        bank[cur_sel] <= st_val;
      end
    end

    // taps lag a transfer so the wiper settles in one move
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        dly      <= 8'h00;
        o_tap[c] <= `WIPER_MIN;
      end else if (ld_wip) begin
        dly <= 8'(WRL_CYCLES);
      end else if (dly != 8'h00) begin
        dly <= dly - 8'h01;
      end else begin
        o_tap[c] <= wcr[c];
      end
    end
  end
endmodule : pot_device

// ---- rtl/pot_host.sv ----
// pot host end: AHB-Lite registers driving the two-wire link
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "pot_params.svh"
module pot_host
  import pot_pkg::*;
#(
  // arbitrary value
  parameter logic [3:0] TYPE_CODE = 4'ha
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  pot_link_if.host         link
);
  host_state_t hstate;
  logic [7:0]  ctl_instr;
  logic [7:0]  ctl_data;
  logic        ctl_up;
  logic [3:0]  dev_addr;
  logic [7:0]  steps_left;
  logic [7:0]  rxsh;
  logic [7:0]  rdata;
  logic        nack;
  logic [1:0]  ph;
  logic [3:0]  bitn;
  logic [1:0]  byten;
  logic [3:0]  tick_cnt;
  logic        dp_wr;
  logic [7:0]  dp_addr;
  logic        sda_s;

  link_sampler #(.W(1)) u_sda (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   (link.sda),
    .o_q     (sda_s),
    .o_prev  ()
  );

  wire        busy    = (hstate != H_IDLE);
  wire        ap      = i_hsel & i_htrans[1] & i_hready;
  wire        go      = dp_wr & (dp_addr == `REG_CMD) & ~busy;
  wire        tick    = (tick_cnt == 4'h0);
  wire [7:0]  stat_lo = {6'h00, nack, busy};
  wire [31:0] rd_val  =
    (i_haddr[7:0] == `REG_CMD)  ? {7'h00, ctl_up, steps_left, ctl_data,
                                   ctl_instr} :
    (i_haddr[7:0] == `REG_ADDR) ? {28'h000_0000, dev_addr} :
    (i_haddr[7:0] == `REG_STAT) ? {16'h0000, rdata, stat_lo} :
                                  32'h0000_0000;
  // data byte only for register access
  wire [1:0]  last    = has_data(ctl_instr[7:4]) ? 2'h2 : 2'h1;
  wire        reading = (byten == 2'h2) & is_read(ctl_instr[7:4]);
  // id byte then instruction then data
  wire [7:0]  cur_tx  = (byten == 2'h0) ? {TYPE_CODE, dev_addr} :
                        (byten == 2'h1) ? ctl_instr : ctl_data;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dp_wr       <= 1'b0;
      dp_addr     <= 8'h00;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      dp_wr   <= ap & i_hwrite;
      dp_addr <= i_haddr[7:0];
      if (ap & ~i_hwrite)
        o_hrdata <= rd_val;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctl_instr <= 8'h00;
      ctl_data  <= 8'h00;
      ctl_up    <= 1'b0;
      dev_addr  <= 4'h0;
    end else if (dp_wr & (dp_addr == `REG_ADDR)) begin
      dev_addr <= i_hwdata[`ADDR_STRAP];
    end else if (go) begin
      ctl_instr <= i_hwdata[`CMD_INSTR];
      ctl_data  <= i_hwdata[`CMD_DATA];
      ctl_up    <= i_hwdata[`CMD_UP];
    end
  end

  // scl is made here, so the link rate is a plain divider
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || go || tick)
      tick_cnt <= `SCL_TICK - 4'h1;
    else
      tick_cnt <= tick_cnt - 4'h1;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hstate             <= H_IDLE;
      ph                 <= 2'h0;
      bitn               <= 4'h0;
      byten              <= 2'h0;
      steps_left         <= 8'h00;
      rxsh               <= 8'h00;
      rdata              <= 8'h00;
      nack               <= 1'b0;
      link.scl           <= 1'b1;
      link.host_sda_oe_n <= 1'b1;
      link.host_sda_o    <= 1'b0;
    end else if (go) begin
      hstate     <= H_START;
      ph         <= 2'h0;
      bitn       <= 4'h0;
      byten      <= 2'h0;
      nack       <= 1'b0;
      steps_left <= i_hwdata[`CMD_STEPS];
    end else if (tick) begin
      unique case (hstate)
        H_IDLE: ;
        H_START: begin
          if (ph == 2'h0) begin
            link.host_sda_oe_n <= 1'b0;
            ph                 <= 2'h1;
          end else begin
            link.scl <= 1'b0;
            ph       <= 2'h0;
            hstate   <= H_BIT;
          end
        end
        H_BIT: begin
          unique case (ph)
            2'h0: begin
              // data changes only while scl is low
              link.host_sda_oe_n <= (bitn == `ACK_BIT) | reading |
                                    cur_tx[~bitn[2:0]];
              ph <= 2'h1;
            end
            2'h1: begin
              link.scl <= 1'b1;
              ph       <= 2'h2;
            end
            2'h2: begin
              link.scl <= 1'b0;
              ph       <= 2'h0;
              if (bitn != `ACK_BIT) begin
                bitn <= bitn + 4'h1;
                rxsh <= {rxsh[6:0], sda_s};
              end else begin
                bitn  <= 4'h0;
                byten <= byten + 2'h1;
                if (reading)
                  rdata <= rxsh;
                if (~reading & sda_s) begin
                  nack   <= 1'b1;
                  hstate <= H_STOP;
                end else if (byten == last) begin
                  hstate <= ((ctl_instr[7:4] == OP_INCDEC) &&
                             (steps_left != 8'h00)) ? H_STEP : H_STOP;
                end
              end
            end
            default: ph <= 2'h0;
          endcase
        end
        H_STEP: begin
          unique case (ph)
            2'h0: begin
              link.host_sda_oe_n <= ctl_up;
              ph                 <= 2'h1;
            end
            2'h1: begin
              link.scl <= 1'b1;
              ph       <= 2'h2;
            end
            2'h2: begin
              link.scl   <= 1'b0;
              ph         <= 2'h0;
              steps_left <= steps_left - 8'h01;
              if (steps_left == 8'h01)
                hstate <= H_STOP;
            end
            default: ph <= 2'h0;
          endcase
        end
        H_STOP: begin
          unique case (ph)
            2'h0: begin
              link.host_sda_oe_n <= 1'b0;
              ph                 <= 2'h1;
            end
            2'h1: begin
              link.scl <= 1'b1;
              ph       <= 2'h2;
            end
            2'h2: begin
              link.host_sda_oe_n <= 1'b1;
              ph                 <= 2'h0;
              hstate             <= H_IDLE;
            end
            default: ph <= 2'h0;
          endcase
        end
      endcase
    end
  end
endmodule : pot_host

// ---- tb/pot_link_chk.sv ----
// concurrent checks on the two-wire link between host and pot device
`timescale 1ns/1ns
module pot_link_chk #(
  parameter int NV_WRITE_CYCLES = 50
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic sda,
  input wire logic o_nv_busy
);
  logic [31:0] nv_cnt;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence high_tick;
    scl [*4];
  endsequence
  sequence low_gap;
    !scl [*4];
  endsequence

  // length of the nonvolatile write, cleared between cycles
  always_ff @(posedge i_clk) begin
    nv_cnt <= (!i_rst_n || !o_nv_busy) ? 32'h0 : nv_cnt + 32'h1;
  end

  host_open_drain_a: assert property (
    host_sda_o == 1'h0) else $error("host drove sda high");
  dev_open_drain_a: assert property (
    dev_sda_o == 1'h0) else $error("device drove sda high");
  // an ack or data bit from the device holds the wire low for at least 8 cycles
  ack_on_wire_a: assert property (
    $fell(dev_sda_oe_n) |-> (!sda) [*8])
    else $error("device pull not held on sda");
  // both may pull low around a clock fall, never while scl is high
  no_clash_a: assert property (
    scl && !dev_sda_oe_n |-> host_sda_oe_n)
    else $error("both ends drive sda");
  // device may only change sda while scl is low
  dev_hold_a: assert property (
    scl && $past(scl) |-> $stable(dev_sda_oe_n))
    else $error("device changed sda during scl high");
  scl_high_a: assert property (
    $rose(scl) |-> high_tick) else $error("scl high shorter than a tick");
  scl_low_a: assert property (
    $fell(scl) |-> low_gap) else $error("scl low shorter than a tick");
  nv_quiet_a: assert property (
    o_nv_busy |-> dev_sda_oe_n) else $error("device acked during write");
  nv_long_a: assert property (
    $fell(o_nv_busy) |-> nv_cnt >= NV_WRITE_CYCLES - 2)
    else $error("nonvolatile write ended early");
  nv_bound_a: assert property (
    nv_cnt <= NV_WRITE_CYCLES + 2) else $error("nonvolatile write too long");
endmodule : pot_link_chk

// ---- tb/test_quad_pot_command_decoder.sv ----
// bench: AHB-Lite host end joined to the pot device over the link
`timescale 1ns/1ns
module test_quad_pot_command_decoder
  import pot_pkg::*;
;
  // arbitrary value
  localparam logic [3:0]  TYPE   = 4'h9;
  localparam int          NV_CYC = 2000;
  localparam logic [31:0] M_NK   = 32'h0000_0003;
  localparam logic [31:0] M_RD   = 32'h0000_ff03;
  logic        i_clk;
  logic        i_rst_n;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [3:0]  strap;
  logic [7:0]  tap [4];
  logic        nv_busy;
  logic [31:0] st;
  logic [7:0]  gx [4];
  logic        ps;
  logic        pd;
  logic [7:0]  sh;
  logic [7:0]  id_seen;
  int          nb = 99;
  int          cyc = 0;
  int          num_errors = 0;
  int          checks_done = 0;

  pot_link_if pot_link_if_i ();
  pot_host #(.TYPE_CODE(TYPE)) pot_host_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(1'h1), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .link(pot_link_if_i.host));
  pot_device #(.TYPE_CODE(TYPE), .NV_WRITE_CYCLES(NV_CYC)) pot_device_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr_strap(strap),
    .link(pot_link_if_i.device), .o_tap(tap), .o_nv_busy(nv_busy));
  pot_link_chk #(.NV_WRITE_CYCLES(NV_CYC)) pot_link_chk_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .scl(pot_link_if_i.scl),
    .host_sda_o(pot_link_if_i.host_sda_o),
    .host_sda_oe_n(pot_link_if_i.host_sda_oe_n),
    .dev_sda_o(pot_link_if_i.dev_sda_o),
    .dev_sda_oe_n(pot_link_if_i.dev_sda_oe_n),
    .sda(pot_link_if_i.sda), .o_nv_busy(nv_busy));

  initial begin
    i_clk = 1'h0;
    forever #25 i_clk = ~i_clk;
  end

  // wire monitor: first byte after each start, sampled on scl rise
  always @(posedge i_clk) begin
    ps <= pot_link_if_i.scl;
    pd <= pot_link_if_i.sda;
    if (ps && pot_link_if_i.scl && pd && !pot_link_if_i.sda) begin
      nb <= 0;
    end else if (!ps && pot_link_if_i.scl) begin
      sh <= {sh[6:0], pot_link_if_i.sda};
      nb <= nb + 1;
      if (nb == 7) begin
        id_seen <= {sh[6:0], pot_link_if_i.sda};
      end
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge i_clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask : ahb

  function automatic logic [31:0] mk(input logic [3:0] op,
      input logic [3:0] sp, input logic [7:0] d, input logic [8:0] su);
    return {7'h0, su, d, op, sp};
  endfunction : mk

  // launch one frame, poll until the host is idle, then compare status
  task automatic run(input logic [31:0] w, input logic [31:0] m,
                     input logic [31:0] e);
    ahb(1'h1, 8'h00, w, st);
    st = 32'h1;
    while (st[0] !== 1'h0) ahb(1'h0, 8'h08, 32'h0, st);
    check(st & m, e);
  endtask : run

  // busy rises a few cycles after the stop, so wait before polling
  task automatic nvw();
    repeat (8) @(posedge i_clk);
    while (nv_busy !== 1'h0) @(posedge i_clk);
  endtask : nvw

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    i_rst_n = 1'h0;
    htrans  = 2'h0;
    haddr   = 32'h0;
    hwrite  = 1'h0;
    hwdata  = 32'h0;
    strap   = 4'h6;
    gx      = '{8'h77, 8'h5a, 8'h00, 8'h00};
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'h1;
    @(posedge i_clk);
    ahb(1'h1, 8'h04, 32'h6, st);
    run(mk(OP_WR_WIPER, 4'h1, 8'h5a, 9'h0), M_NK, 32'h0);
    check({24'h0, id_seen}, {24'h0, TYPE, 4'h6});
    run(mk(OP_RD_WIPER, 4'h1, 8'h0, 9'h0), M_RD, 32'h5a00);
    check({24'h0, tap[1]}, 32'h5a);
    $display("test wiper done");
    run(mk(OP_WR_STORE, 4'ha, 8'h33, 9'h0), M_NK, 32'h0);
    nvw();
    run(mk(OP_RD_STORE, 4'ha, 8'h0, 9'h0), M_RD, 32'h3300);
    run(mk(OP_WR_STORE, 4'h4, 8'h77, 9'h0), M_NK, 32'h0);
    run(mk(OP_RD_WIPER, 4'h0, 8'h0, 9'h0), M_NK, 32'h2);
    nvw();
    run(mk(OP_RD_STORE, 4'h4, 8'h0, 9'h0), M_RD, 32'h7700);
    $display("test store done");
    run(mk(OP_XFR_TO_WIPER, 4'ha, 8'h0, 9'h0), M_NK, 32'h0);
    repeat (24) @(posedge i_clk);
    check({24'h0, tap[2]}, 32'h33);
    run(mk(OP_XFR_TO_STORE, 4'h5, 8'h0, 9'h0), M_NK, 32'h0);
    nvw();
    run(mk(OP_RD_STORE, 4'h5, 8'h0, 9'h0), M_RD, 32'h5a00);
    $display("test transfer done");
    run(mk(OP_GXFR_TO_WIPER, 4'h4, 8'h0, 9'h0), M_NK, 32'h0);
    repeat (24) @(posedge i_clk);
    for (int p = 0; p < 4; p++) begin
      check({24'h0, tap[p]}, {24'h0, gx[p]});
    end
    run(mk(OP_GXFR_TO_STORE, 4'hc, 8'h0, 9'h0), M_NK, 32'h0);
    nvw();
    for (int p = 0; p < 4; p++) begin
      run(mk(OP_RD_STORE, {2'h3, p[1:0]}, 8'h0, 9'h0), M_RD,
          {16'h0, gx[p], 8'h0});
    end
    $display("test global done");
    run(mk(OP_INCDEC, 4'h3, 8'h0, 9'h103), M_NK, 32'h0);
    run(mk(OP_RD_WIPER, 4'h3, 8'h0, 9'h0), M_RD, 32'h0300);
    run(mk(OP_INCDEC, 4'h3, 8'h0, 9'h005), M_NK, 32'h0);
    run(mk(OP_RD_WIPER, 4'h3, 8'h0, 9'h0), M_RD, 32'h0);
    run(mk(OP_WR_WIPER, 4'h3, 8'hfe, 9'h0), M_NK, 32'h0);
    run(mk(OP_INCDEC, 4'h3, 8'h0, 9'h103), M_NK, 32'h0);
    run(mk(OP_RD_WIPER, 4'h3, 8'h0, 9'h0), M_RD, 32'hff00);
    $display("test step done");
    run(mk(OP_RD_WIPER, 4'h4, 8'h0, 9'h0), M_NK, 32'h2);
    run(mk(OP_GXFR_TO_WIPER, 4'h1, 8'h0, 9'h0), M_NK, 32'h2);
    ahb(1'h1, 8'h04, 32'h7, st);
    run(mk(OP_RD_WIPER, 4'h1, 8'h0, 9'h0), M_NK, 32'h2);
    ahb(1'h1, 8'h04, 32'h6, st);
    run(mk(OP_RD_WIPER, 4'h1, 8'h0, 9'h0), M_RD, 32'h5a00);
    ahb(1'h0, 8'h0c, 32'h0, st);
    check(st, 32'h0);
    check({31'h0, hresp}, 32'h0);
    ahb(1'h0, 8'h04, 32'h0, st);
    check(st, 32'h6);
    ahb(1'h0, 8'h00, 32'h0, st);
    check(st, 32'h91);
    $display("test refusal done");
    tally_and_finish();
  end
endmodule : test_quad_pot_command_decoder
